// File: rtl/irq_bank_pkg.sv
// Constants for the interrupt enable and request flag bank.
// Assumes an 8-bit register port and a single system clock.
// Behaviour
// RULE1 - Eight-bit enable: direct transfer, timers E-A
// RULE2 - Timer enable bits 4..0 gate timers E..A
// RULE3 - Top two enable bits are plain storage
// RULE4 - Request forwarded only when flag and enable
// RULE5 - Second enable bit 7 gates A/D done
// RULE6 - Second enable bit 6 gates key scan
// RULE7 - Second enable bits 1,0 gate serial 2,1
// RULE8 - Second enable bits 5..2 read one, fixed
// RULE9 - Pin flags set on chosen edge when enabled
// RULE10 - Flags clear on written zero only
// RULE11 - Flags stay set until software clears
// RULE12 - External flag bits 7,6 one; 3,2 zero
// RULE13 - External flags reset zero, top bits one
// RULE14 - Timer/transfer flags set by source, reset zero
// RULE15 - Timer/transfer flag bits 7,6 read zero
// RULE16 - Pins 0,1,4 edge selectable, falling default
// RULE17 - Pin 5 detects falling edge only
// RULE18 - Pin function bit must be set first
// RULE19 - Source set beats software clear
`default_nettype none
package irq_bank_pkg;
	localparam int ADDR_W = 4;                      // Register address width
	localparam int DATA_W = 8;                      // Register data width
	localparam int NPIN   = 4;                      // External pins 5,4,1,0
	localparam int NTD    = 6;                      // Transfer plus five timers
	localparam int NPER   = 4;                      // A/D, key scan, serial 2,1

	// Register addresses
	localparam logic [3:0] A_TD_EN    = 4'h0;       // timer_direct_irq_enable
	localparam logic [3:0] A_PER_EN   = 4'h1;       // peripheral_irq_enable
	localparam logic [3:0] A_EXT_FLG  = 4'h2;       // external_irq_flags
	localparam logic [3:0] A_TD_FLG   = 4'h3;       // timer_direct_irq_flags
	localparam logic [3:0] A_PIN_FUNC = 4'h4;       // pin_function_select
	localparam logic [3:0] A_EDGE_POL = 4'h5;       // edge_polarity_select
	localparam logic [3:0] A_STATUS   = 4'h6;       // Sticky event status
	localparam logic [3:0] A_MASK     = 4'h7;       // Event mask

	// Reset values
	localparam logic [7:0] RST_ZERO   = 8'h00;      // Cleared register
	localparam logic [3:0] RST_SYNC   = 4'hf;       // Pins idle high

	// Fixed bits and field positions
	localparam logic [1:0] EXT_TOP_ONE = 2'h3;      // External bits 7,6
	localparam logic [1:0] EXT_MID_ZRO = 2'h0;      // External bits 3,2
	localparam logic [3:0] PER_FIXED   = 4'hf;      // Peripheral bits 5..2
	localparam logic [1:0] TD_TOP_ZRO  = 2'h0;      // Flag bits 7,6
	localparam logic [1:0] PF_MID_ONE  = 2'h3;      // Pin function bits 3,2
	localparam logic [1:0] EP_MID_ONE  = 2'h3;      // Edge select bits 3,2
	localparam logic [1:0] EP_TOP_ONE  = 2'h3;      // Edge select bits 7,6
	localparam logic       EP_B5_ONE   = 1'h1;      // Edge select bit 5
	localparam int         PIN5_IDX    = 3;         // Pin 5 in pin vector
endpackage : irq_bank_pkg
`default_nettype wire

// File: rtl/irq_enable_and_flag_bank.sv
// Enable registers, request flags and edge detectors of the interrupt bank.
// Assumes peripherals on clk give one-cycle set pulses or levels, and the
// external pins are asynchronous and need synchronising.
`timescale 1ns/100ps
`default_nettype none
module irq_enable_and_flag_bank (
	input  wire logic        clk,             // System clock, 10 MHz
	input  wire logic        rstn,            // Async reset, active low
	input  wire logic        ce,              // Clock enable, freezes state
	input  wire logic [3:0]  addr,            // Register address
	input  wire logic [7:0]  wdata,           // Write data
	input  wire logic        wr,              // Write strobe
	input  wire logic        rd,              // Read strobe
	output logic      [7:0]  rdata,           // Read data, cycle after rd
	input  wire logic [3:0]  ext_pins,        // Pins {5,4,1,0}
	input  wire logic        direct_transfer_req, // Set pulse
	input  wire logic [4:0]  timer_ovf_req,   // Set pulses {E,D,C,B,A}
	input  wire logic        adc_done_flag,   // Flag level
	input  wire logic        keyscan_flag,    // Flag level
	input  wire logic        serial2_flag,    // Flag level
	input  wire logic        serial1_flag,    // Flag level
	output logic      [3:0]  ext_flags,       // Pin flags {5,4,1,0}
	output logic      [5:0]  td_request,      // Gated transfer/timer
	output logic      [3:0]  per_request,     // Gated {ad,ks,s2,s1}
	output logic             irq              // Masked event interrupt
);
	// Register state
	logic [7:0]      td_en_reg;               // Transfer/timer enables
	logic [1:0]      per_hi_reg;              // A/D, key scan enables
	logic [1:0]      per_lo_reg;              // Serial 2,1 enables
	logic [3:0]      ext_flg_reg;             // External pin flags
	logic [5:0]      td_flg_reg;              // Transfer/timer flags
	logic [3:0]      pin_func_reg;            // Pin interrupt function
	logic [2:0]      edge_pol_reg;            // Edge select pins 4,1,0
	logic [7:0]      status_reg;              // Sticky events
	logic [7:0]      mask_reg;                // Event mask
	logic [7:0]      rdata_reg;               // Read data
	logic [3:0]      ext_out_reg;             // Registered pin flags
	logic [5:0]      td_req_reg;              // Registered gated requests
	logic [3:0]      per_req_reg;             // Registered gated requests
	logic            irq_reg;                 // Registered interrupt
	// Pin synchroniser and edge history
	logic [3:0]      sync1_reg;               // First stage
	logic [3:0]      sync2_reg;               // Second stage
	logic [3:0]      prev_reg;                // Previous synced level
	// Combinational
	logic [3:0]      rise;                    // Rising edge seen
	logic [3:0]      fall;                    // Falling edge seen
	logic [3:0]      pol;                     // Per-pin rising select
	logic [3:0]      ext_set;                 // Pin flag set events
	logic [5:0]      td_set;                  // Transfer/timer set events
	logic [7:0]      events;                  // Status event vector
	logic [7:0]      rd_mux;                  // Read multiplexer
	logic [3:0]      per_flags;               // Peripheral flag levels
	logic [3:0]      per_en;                  // Peripheral enables
	logic [5:0]      ext_wide;                // Pin flags padded to six
	logic [3:0]      ext_flg_next;            // Next pin flag value

	// Write-zero-to-clear with set priority
	function automatic logic [5:0] w0c(
		input logic [5:0] old,
		input logic [5:0] wd,
		input logic       hit,
		input logic [5:0] set
	);
		w0c = (hit ? (old & wd) : old) | set;
	endfunction : w0c

	// Address decode of a strobe
	function automatic logic hit(
		input logic       strobe,
		input logic [3:0] a,
		input logic [3:0] target
	);
		hit = strobe && (a == target);
	endfunction : hit

	// Two-flop synchroniser for the external pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Idle-high reset, so no false falling edge follows
			sync1_reg <= irq_bank_pkg::RST_SYNC;
			sync2_reg <= irq_bank_pkg::RST_SYNC;
			prev_reg  <= irq_bank_pkg::RST_SYNC;
		end else if (ce) begin
			sync1_reg <= ext_pins;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Edge detection and flag set conditions
	always_comb begin
		rise = sync2_reg & ~prev_reg;
		fall = ~sync2_reg & prev_reg;
		// Pin 5 has no select, always falling
		pol = {1'b0, edge_pol_reg};                        // RULE16 RULE17
		// Chosen edge and function bit both required
		ext_set = pin_func_reg & ((pol & rise) | (~pol & fall)); // RULE9 RULE18
		td_set = {direct_transfer_req, timer_ovf_req};      // RULE14
		events = {2'h0, |timer_ovf_req, direct_transfer_req, ext_set};
		per_flags = {adc_done_flag, keyscan_flag, serial2_flag, serial1_flag};
		per_en = {per_hi_reg, per_lo_reg};
		// Pin flags share the six-bit clear helper, top bits padded
		ext_wide = w0c({2'h0, ext_flg_reg},
			{2'h0, wdata[5:4], wdata[1:0]},
			hit(wr, addr, irq_bank_pkg::A_EXT_FLG),
			{2'h0, ext_set});                               // RULE10 RULE19
		ext_flg_next = ext_wide[3:0];
	end

	// Transfer/timer enable, all eight bits stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			td_en_reg <= irq_bank_pkg::RST_ZERO;           // RULE1
		end else if (ce && hit(wr, addr, irq_bank_pkg::A_TD_EN)) begin
			// Reserved top bits are plain storage as well
			td_en_reg <= wdata;                             // RULE1 RULE3
		end
	end

	// Peripheral enable, bits 5..2 not stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			per_hi_reg <= 2'h0;
			per_lo_reg <= 2'h0;
		end else if (ce && hit(wr, addr, irq_bank_pkg::A_PER_EN)) begin
			// Bits 5..2 read as ones and are never stored
			per_hi_reg <= wdata[7:6];                       // RULE5 RULE6
			per_lo_reg <= wdata[1:0];                       // RULE7
		end
	end

	// External pin flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_flg_reg <= 4'h0;                            // RULE13
		end else if (ce) begin
			// Only written zeros clear; sets win
			ext_flg_reg <= ext_flg_next;                    // RULE10 RULE19
		end
	end

	// Transfer/timer flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			td_flg_reg <= 6'h00;                            // RULE14
		end else if (ce) begin
			// Acceptance by the CPU leaves them alone
			td_flg_reg <= w0c(td_flg_reg, wdata[5:0],
				hit(wr, addr, irq_bank_pkg::A_TD_FLG),
				td_set);                                    // RULE10 RULE11 RULE19
		end
	end

	// Pin function and edge select
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_func_reg <= 4'h0;
			edge_pol_reg <= 3'h0;                           // RULE16
		end else if (ce) begin
			if (hit(wr, addr, irq_bank_pkg::A_PIN_FUNC)) begin
				pin_func_reg <= {wdata[5:4], wdata[1:0]};
			end
			if (hit(wr, addr, irq_bank_pkg::A_EDGE_POL)) begin
				edge_pol_reg <= {wdata[4], wdata[1:0]};
			end
		end
	end

	// Sticky status, cleared by its read, events win
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_reg <= irq_bank_pkg::RST_ZERO;
			mask_reg   <= irq_bank_pkg::RST_ZERO;
		end else if (ce) begin
			if (hit(rd, addr, irq_bank_pkg::A_STATUS)) begin
				// Read clears, an event in the same cycle stays
				status_reg <= events;
			end else begin
				status_reg <= status_reg | events;
			end
			if (hit(wr, addr, irq_bank_pkg::A_MASK)) begin
				mask_reg <= wdata;
			end
		end
	end

	// Read multiplexer with fixed reserved bits
	always_comb begin
		case (addr)
			irq_bank_pkg::A_TD_EN:    rd_mux = td_en_reg;
			irq_bank_pkg::A_PER_EN:   rd_mux = {per_hi_reg,
				irq_bank_pkg::PER_FIXED, per_lo_reg};       // RULE8
			irq_bank_pkg::A_EXT_FLG:  rd_mux = {irq_bank_pkg::EXT_TOP_ONE,
				ext_flg_reg[3:2], irq_bank_pkg::EXT_MID_ZRO,
				ext_flg_reg[1:0]};                          // RULE12
			irq_bank_pkg::A_TD_FLG:   rd_mux = {irq_bank_pkg::TD_TOP_ZRO,
				td_flg_reg};                                // RULE15
			irq_bank_pkg::A_PIN_FUNC: rd_mux = {2'h0, pin_func_reg[3:2],
				irq_bank_pkg::PF_MID_ONE, pin_func_reg[1:0]};
			irq_bank_pkg::A_EDGE_POL: rd_mux = {irq_bank_pkg::EP_TOP_ONE,
				irq_bank_pkg::EP_B5_ONE, edge_pol_reg[2],
				irq_bank_pkg::EP_MID_ONE, edge_pol_reg[1:0]};
			irq_bank_pkg::A_STATUS:   rd_mux = status_reg;
			irq_bank_pkg::A_MASK:     rd_mux = mask_reg;
			default:                  rd_mux = irq_bank_pkg::RST_ZERO;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= irq_bank_pkg::RST_ZERO;
		end else if (ce) begin
			// Zero between reads so stale data never shows
			rdata_reg <= rd ? rd_mux : irq_bank_pkg::RST_ZERO;
		end
	end

	// Gated requests toward the CPU
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			td_req_reg  <= 6'h00;
			per_req_reg <= 4'h0;
			ext_out_reg <= 4'h0;
			irq_reg     <= 1'b0;
		end else if (ce) begin
			// One cycle behind the flags and enables
			td_req_reg  <= td_flg_reg & td_en_reg[5:0];     // RULE2 RULE4
			per_req_reg <= per_flags & per_en;              // RULE4 RULE5
			ext_out_reg <= ext_flg_reg;
			irq_reg     <= |(status_reg & mask_reg);
		end
	end

	assign rdata       = rdata_reg;
	assign ext_flags   = ext_out_reg;
	assign td_request  = td_req_reg;
	assign per_request = per_req_reg;
	assign irq         = irq_reg;

	// Checks
	a_td_en_store: assert property (@(posedge clk) disable iff (!rstn) // RULE1
		ce && hit(wr, addr, irq_bank_pkg::A_TD_EN) |=> td_en_reg == $past(wdata))
		else $error("Transfer/timer enable not stored");
	a_td_rsv_rd: assert property (@(posedge clk) disable iff (!rstn) // RULE3
		ce && hit(rd, addr, irq_bank_pkg::A_TD_EN)
		|=> rdata[7:6] == $past(td_en_reg[7:6]))
		else $error("Reserved enable bits not read back");
	a_td_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE2
		ce |=> td_request == ($past(td_flg_reg) & $past(td_en_reg[5:0])))
		else $error("Timer request gating wrong");
	a_per_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE4
		ce |=> per_request == ($past(per_flags) & $past(per_en)))
		else $error("Peripheral request gating wrong");
	a_per_fixed: assert property (@(posedge clk) disable iff (!rstn) // RULE8
		ce && hit(rd, addr, irq_bank_pkg::A_PER_EN) |=> rdata[5:2] == 4'hf)
		else $error("Peripheral reserved bits not one");
	a_ext_set_win: assert property (@(posedge clk) disable iff (!rstn) // RULE19
		ce |=> (ext_flg_reg & $past(ext_set)) == $past(ext_set))
		else $error("Pin flag set lost");
	a_ext_fixed: assert property (@(posedge clk) disable iff (!rstn) // RULE12
		ce && hit(rd, addr, irq_bank_pkg::A_EXT_FLG)
		|=> rdata[7:6] == 2'h3 && rdata[3:2] == 2'h0)
		else $error("External reserved bits wrong");
	a_td_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE11
		ce && !hit(wr, addr, irq_bank_pkg::A_TD_FLG)
		|=> (td_flg_reg & $past(td_flg_reg)) == $past(td_flg_reg))
		else $error("Flag fell without a write");
	a_w1_keeps: assert property (@(posedge clk) disable iff (!rstn) // RULE10
		ce && hit(wr, addr, irq_bank_pkg::A_TD_FLG) && wdata[5:0] == 6'h3f
		|=> (td_flg_reg & $past(td_flg_reg)) == $past(td_flg_reg))
		else $error("Writing one changed a flag");
	a_td_top_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE15
		ce && hit(rd, addr, irq_bank_pkg::A_TD_FLG) |=> rdata[7:6] == 2'h0)
		else $error("Flag reserved bits not zero");
	a_pin5_fall: assert property (@(posedge clk) disable iff (!rstn) // RULE17
		ext_set[3] |-> fall[3])
		else $error("Pin 5 set without falling edge");
	a_pin_func: assert property (@(posedge clk) disable iff (!rstn) // RULE9
		ce && !pin_func_reg[0] && !hit(wr, addr, irq_bank_pkg::A_EXT_FLG)
		|=> ext_flg_reg[0] == $past(ext_flg_reg[0]))
		else $error("Pin 0 flag moved with function off");

	// Reset values, checked while reset is held
	a_reset_vals: assert property (@(posedge clk) // RULE13
		!rstn |-> td_en_reg == 8'h00 && td_flg_reg == 6'h00
		&& ext_flg_reg == 4'h0)
		else $error("Register not at reset value");

	// Written zeros clear exactly the addressed flags
	a_ext_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE10
		ce && hit(wr, addr, irq_bank_pkg::A_EXT_FLG) && ext_set == 4'h0
		|=> ext_flg_reg == ($past(ext_flg_reg)
		& {$past(wdata[5:4]), $past(wdata[1:0])}))
		else $error("Pin flag clear wrong");
	a_td_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE10
		ce && hit(wr, addr, irq_bank_pkg::A_TD_FLG) && td_set == 6'h00
		|=> td_flg_reg == ($past(td_flg_reg) & $past(wdata[5:0])))
		else $error("Transfer/timer flag clear wrong");
	a_func_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE9
		ce && !pin_func_reg[1] && !hit(wr, addr, irq_bank_pkg::A_EXT_FLG)
		|=> ext_flg_reg[1] == $past(ext_flg_reg[1]))
		else $error("Pin 1 flag moved with function off");

	// Source requests always land
	a_td_set: assert property (@(posedge clk) disable iff (!rstn) // RULE14
		ce && td_set != 6'h00
		|=> (td_flg_reg & $past(td_set)) == $past(td_set))
		else $error("Transfer/timer set lost");
	a_ext_pad: assert property (@(posedge clk) disable iff (!rstn) // RULE10
		ext_wide[5:4] == 2'h0)
		else $error("Pin flag padding not zero");

	// Chosen edge only, per pin select
	a_pin_edge: assert property (@(posedge clk) disable iff (!rstn) // RULE16
		ext_set[0] |-> (edge_pol_reg[0] ? rise[0] : fall[0]))
		else $error("Pin 0 set on the wrong edge");
	a_edge_store: assert property (@(posedge clk) disable iff (!rstn) // RULE16
		ce && hit(wr, addr, irq_bank_pkg::A_EDGE_POL)
		|=> edge_pol_reg == {$past(wdata[4]), $past(wdata[1:0])})
		else $error("Edge select not stored");

	// Peripheral enable storage and serial gating
	a_per_store: assert property (@(posedge clk) disable iff (!rstn) // RULE6
		ce && hit(wr, addr, irq_bank_pkg::A_PER_EN)
		|=> per_en == {$past(wdata[7:6]), $past(wdata[1:0])})
		else $error("Peripheral enable not stored");
	a_ser_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE7
		ce |=> per_request[1:0]
		== ($past(per_flags[1:0]) & $past(per_lo_reg)))
		else $error("Serial request gating wrong");

	// Fixed bits of the pin function and edge select reads
	a_pf_fixed: assert property (@(posedge clk) disable iff (!rstn)
		ce && hit(rd, addr, irq_bank_pkg::A_PIN_FUNC)
		|=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h3)
		else $error("Pin function fixed bits wrong");
	a_ep_fixed: assert property (@(posedge clk) disable iff (!rstn) // RULE16
		ce && hit(rd, addr, irq_bank_pkg::A_EDGE_POL)
		|=> rdata[7:5] == 3'h7 && rdata[3:2] == 2'h3)
		else $error("Edge select fixed bits wrong");

	// Read port: data only after a strobe, unmapped reads zero
	a_rd_idle: assert property (@(posedge clk) disable iff (!rstn)
		ce && !rd |=> rdata == 8'h00)
		else $error("Read data without a read");
	a_unmapped: assert property (@(posedge clk) disable iff (!rstn)
		ce && rd && addr[3] |=> rdata == 8'h00)
		else $error("Unmapped read not zero");

	// Status stickiness, interrupt level and clock enable hold
	a_stat_keep: assert property (@(posedge clk) disable iff (!rstn)
		ce && !hit(rd, addr, irq_bank_pkg::A_STATUS)
		|=> (status_reg & $past(status_reg)) == $past(status_reg))
		else $error("Status bit fell without a read");
	a_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> irq == |($past(status_reg) & $past(mask_reg)))
		else $error("Interrupt level wrong");
	a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn)
		!ce |=> td_flg_reg == $past(td_flg_reg)
		&& ext_flg_reg == $past(ext_flg_reg))
		else $error("Flags moved with clock enable low");

	// Scenario covers
	c_ext_set: cover property (@(posedge clk) disable iff (!rstn)
		ce && ext_set != 4'h0);
	c_collide: cover property (@(posedge clk) disable iff (!rstn)
		ce && td_set != 6'h00 && hit(wr, addr, irq_bank_pkg::A_TD_FLG));
	c_irq_rise: cover property (@(posedge clk) disable iff (!rstn)
		$rose(irq));
	c_pin_rise: cover property (@(posedge clk) disable iff (!rstn)
		ce && (ext_set & pol) != 4'h0);
	c_ce_low: cover property (@(posedge clk) disable iff (!rstn)
		!ce && wr);
endmodule : irq_enable_and_flag_bank
`default_nettype wire

// File: tb/periph_model.sv
// Model of the peripherals and pins that feed the interrupt bank.
// Assumes the bench asks for each event one clock ahead, for one clock.
`timescale 1ns/100ps
`default_nettype none
module periph_model (
	input  wire logic       clk,     // System clock
	input  wire logic       rstn,    // Async reset, active low
	input  wire logic [5:0] fire,    // Event requests {dt,E,D,C,B,A}
	input  wire logic [3:0] lvl,     // Levels {ad,ks,s2,s1}
	input  wire logic [3:0] pins,    // Pin levels {5,4,1,0}
	output logic            dt_req,  // Transfer set pulse
	output logic      [4:0] tmr_req, // Overflow set pulses
	output logic      [3:0] lvl_out, // Peripheral flag levels
	output logic      [3:0] pin_out  // Pin wires, idle high
);
	// Launch every change just after the edge, as on-chip logic would
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{dt_req, tmr_req} <= 6'h00;
			lvl_out           <= 4'h0;
			pin_out           <= 4'hf;
		end else begin
			{dt_req, tmr_req} <= fire;
			lvl_out           <= lvl;
			pin_out           <= pins;
		end
	end
endmodule : periph_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the interrupt enable and request flag bank.
// Assumes the bank package and the peripheral model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic       clk, rstn, ce, wr, rd;      // Clock, reset, bus strobes
	logic [3:0] addr, lvl, pins;            // Address, level, pin stimulus
	logic [7:0] wdata, rdata, r, d;         // Bus data and scratch
	logic [5:0] fire, t, m, td_request;     // Events, masks, requests
	logic       dt_req, irq;                // Model pulse, interrupt
	logic [4:0] tmr_req;                    // Model overflow pulses
	logic [3:0] lvl_w, pin_w, ext_flags, per_request; // Far-side wires
	int         error_cnt, compares, cyc;   // Counters

	// Bank under test, clock enable held on except in the clock enable test
	irq_enable_and_flag_bank uut (
		.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .ext_pins(pin_w),
		.direct_transfer_req(dt_req), .timer_ovf_req(tmr_req),
		.adc_done_flag(lvl_w[3]), .keyscan_flag(lvl_w[2]),
		.serial2_flag(lvl_w[1]), .serial1_flag(lvl_w[0]),
		.ext_flags(ext_flags), .td_request(td_request),
		.per_request(per_request), .irq(irq));
	// Peripherals and pins on the far side
	periph_model model (
		.clk(clk), .rstn(rstn), .fire(fire), .lvl(lvl), .pins(pins),
		.dt_req(dt_req), .tmr_req(tmr_req), .lvl_out(lvl_w),
		.pin_out(pin_w));

	// Free-running 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end

	// Read-back of the peripheral enable: bits 5..2 stay high
	function automatic logic [7:0] per_rd(input logic [7:0] w);
		return (w & 8'hc3) | 8'h3c;
	endfunction : per_rd
	// Peripheral enable bits in request order {ad,ks,s2,s1}
	function automatic logic [3:0] per_en(input logic [7:0] w);
		return {w[7], w[6], w[1], w[0]};
	endfunction : per_en

	// Compare one value, count it, report a difference
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One-cycle write
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk) wr <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk) wr <= 1'b0;
	endtask : wr_reg
	// One-cycle read, data taken in the following cycle
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk) rd <= 1'b1;
		addr <= a;
		@(posedge clk) rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	// Read and compare
	task automatic rchk(input logic [3:0] a, input logic [7:0] e,
		input string n);
		logic [7:0] v;
		rd_reg(a, v);
		chk(n, e, v);
	endtask : rchk
	// Wait whole cycles, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// One-cycle event burst from the peripherals
	task automatic ev(input logic [5:0] v);
		@(posedge clk) fire <= v;
		@(posedge clk) fire <= 6'h00;
		wt(2);
	endtask : ev
	// Counts, verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// Main sequence
	initial begin
		{rstn, wr, rd, addr, wdata, fire, lvl} = '0;
		{ce, pins} = 5'h1f;
		{error_cnt, compares, cyc} = '0;
		void'($urandom(57));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		#1;
		// Reset values and an unmapped place
		chk("irq", 8'h00, {7'h0, irq});
		rchk(irq_bank_pkg::A_TD_EN, 8'h00, "td_en");
		rchk(irq_bank_pkg::A_PER_EN, 8'h3c, "per_en");
		rchk(irq_bank_pkg::A_EXT_FLG, 8'hc0, "ext_flg");
		rchk(irq_bank_pkg::A_TD_FLG, 8'h00, "td_flg");
		rchk({1'b1, 3'($urandom)}, 8'h00, "unmapped");
		$display("test reset done");
		// Enable registers, corners first, then random
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			wr_reg(irq_bank_pkg::A_TD_EN, r);
			rchk(irq_bank_pkg::A_TD_EN, r, "td_en");
			wr_reg(irq_bank_pkg::A_PER_EN, r);
			rchk(irq_bank_pkg::A_PER_EN, per_rd(r), "per_en");
			@(posedge clk) lvl <= (i == 0) ? 4'hf : 4'($urandom);
			wt(3);
			chk("per_req", {4'h0, lvl & per_en(r)}, {4'h0, per_request});
		end
		$display("test enables done");
		// Timer and transfer flags
		wr_reg(irq_bank_pkg::A_TD_EN, 8'h3f);
		t = 6'($urandom) | 6'h21;
		ev(t);
		rchk(irq_bank_pkg::A_TD_FLG, {2'h0, t}, "td_flg");
		chk("td_req", {2'h0, t}, {2'h0, td_request});
		wr_reg(irq_bank_pkg::A_TD_FLG, 8'h3f);
		wt(10);
		rchk(irq_bank_pkg::A_TD_FLG, {2'h0, t}, "td_flg");
		wr_reg(irq_bank_pkg::A_TD_EN, 8'h00);
		wt(2);
		chk("td_req", 8'h00, {2'h0, td_request});
		rchk(irq_bank_pkg::A_TD_FLG, {2'h0, t}, "td_flg");
		m = 6'($urandom);
		wr_reg(irq_bank_pkg::A_TD_FLG, {2'h0, m});
		rchk(irq_bank_pkg::A_TD_FLG, {2'h0, t & m}, "td_flg");
		// Source set in the same cycle as a clearing write
		@(posedge clk) fire <= 6'h01;
		@(posedge clk) fire <= 6'h00;
		wr    <= 1'b1;
		addr  <= irq_bank_pkg::A_TD_FLG;
		wdata <= 8'h00;
		@(posedge clk) wr <= 1'b0;
		rchk(irq_bank_pkg::A_TD_FLG, 8'h01, "td_flg");
		$display("test timer flags done");
		// Pins: 5,4,0 enabled, pin 4 on rising edge, pin 1 left as port
		wr_reg(irq_bank_pkg::A_PIN_FUNC, 8'h31);
		wr_reg(irq_bank_pkg::A_EDGE_POL, 8'h10);
		@(posedge clk) pins <= 4'h0;
		wt(6);
		rchk(irq_bank_pkg::A_EXT_FLG, 8'he1, "ext_flg");
		chk("ext_flags", 8'h09, {4'h0, ext_flags});
		wr_reg(irq_bank_pkg::A_EXT_FLG, 8'h00);
		@(posedge clk) pins <= 4'hf;
		wt(6);
		rchk(irq_bank_pkg::A_EXT_FLG, 8'hd0, "ext_flg");
		wr_reg(irq_bank_pkg::A_EXT_FLG, 8'hff);
		rchk(irq_bank_pkg::A_EXT_FLG, 8'hd0, "ext_flg");
		$display("test pins done");
		// Event status, mask and interrupt line
		// Timer overflow is status bit 5, direct transfer bit 4
		wr_reg(irq_bank_pkg::A_MASK, 8'h20);
		rd_reg(irq_bank_pkg::A_STATUS, d);
		wt(2);
		chk("irq", 8'h00, {7'h0, irq});
		ev(6'h02);
		chk("irq", 8'h01, {7'h0, irq});
		rchk(irq_bank_pkg::A_STATUS, 8'h20, "status");
		wt(2);
		chk("irq", 8'h00, {7'h0, irq});
		wr_reg(irq_bank_pkg::A_MASK, 8'h00);
		ev(6'h20);
		chk("irq", 8'h00, {7'h0, irq});
		rchk(irq_bank_pkg::A_STATUS, 8'h10, "status");
		$display("test interrupt done");
		// Clock enable low: a mask write must be ignored
		@(posedge clk) ce <= 1'b0;
		wr_reg(irq_bank_pkg::A_MASK, 8'hff);
		ce <= 1'b1;
		rchk(irq_bank_pkg::A_MASK, 8'h00, "mask");
		$display("test clock enable done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
